// ===== lcb_blink_timing.sv
// blink timing registers, sequence step counter and dimming pwm
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module lcb_blink_timing
	import lcb_pkg::*;
#(
	parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEF
) (
	// clock, reset, enable
	input  wire logic              i_clock,
	input  wire logic              i_resetn,
	input  wire logic              i_clock_en,
	// register port
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	// sequencer side
	input  wire logic              i_seq_enable,
	output logic                   o_channel_drive_out,
	output logic                   o_phase_four_active,
	output logic      [STEP_W-1:0] o_phase_four_steps,
	output logic      [STEP_W-1:0] o_period_steps,
	output logic      [ON_W-1:0]   o_on_interval_steps,
	output logic      [DUTY_W-1:0] o_dimming_duty_value
);
	lcb_tick_if tick ();

	lcb_timebase #(
		.SLOT_CYCLES (SLOT_CYCLES)
	) u_timebase (
		.i_clock    (i_clock),
		.i_resetn   (i_resetn),
		.i_clock_en (i_clock_en),
		.tick       (tick.src)
	);

	// register state
	logic [STEP_W-1:0] phase_four_steps;
	logic [STEP_W-1:0] period_steps;
	logic [DUTY_W-1:0] dimming_duty_value;
	logic [ON_W-1:0]   on_interval_steps;
	logic [STEP_W-1:0] next_phase_four_steps;
	logic [STEP_W-1:0] next_period_steps;
	logic [DUTY_W-1:0] next_dimming_duty_value;
	logic [ON_W-1:0]   next_on_interval_steps;
	logic [DATA_W-1:0] next_rdata;

	// sequence state
	logic [STEP_W-1:0] step;
	logic [STEP_W-1:0] next_step;
	logic              next_drive;
	logic              next_phase_four;
	logic              seq_on;
	logic              gate;
	logic              pwm_high;
	logic [STEP_W:0]   step_plus;
	logic [STEP_W:0]   on_ext;
	logic [STEP_W:0]   p4_end;

	// register writes, only the documented bits are stored
	// unused bits dropped
	always_comb begin
		next_phase_four_steps   = phase_four_steps;
		next_period_steps       = period_steps;
		next_dimming_duty_value = dimming_duty_value;
		next_on_interval_steps  = on_interval_steps;
		if (i_wr) begin
			if (i_addr == ADDR_PHASE_FOUR) begin
				next_phase_four_steps = i_wdata[STEP_W-1:0];
			end else if (i_addr == ADDR_PERIOD) begin
				next_period_steps = i_wdata[STEP_W-1:0];
			end else if (i_addr == ADDR_DUTY) begin
				next_dimming_duty_value = i_wdata[DUTY_W-1:0];
			end else if (i_addr == ADDR_ON_TIME) begin
				next_on_interval_steps = i_wdata[ON_W-1:0];
			end
		end
	end

	// read data stand for one cycle only, unmapped reads give zero
	// reserved bits zero
	always_comb begin
		next_rdata = RDATA_IDLE;
		if (i_rd) begin
			if (i_addr == ADDR_PHASE_FOUR) begin
				next_rdata = {1'b0, phase_four_steps};
			end else if (i_addr == ADDR_PERIOD) begin
				next_rdata = {1'b0, period_steps};
			end else if (i_addr == ADDR_DUTY) begin
				next_rdata = {3'h0, dimming_duty_value};
			end else if (i_addr == ADDR_ON_TIME) begin
				next_rdata = {3'h0, on_interval_steps};
			end else if (i_addr == ADDR_STEP) begin
				next_rdata = {1'b0, step};
			end else if (i_addr == ADDR_STATUS) begin
				next_rdata = {6'h00, o_phase_four_active,
					o_channel_drive_out};
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_four_steps   <= STEP_RESET;
			period_steps       <= STEP_RESET;
			dimming_duty_value <= DUTY_RESET;
			on_interval_steps  <= ON_RESET;
			o_rdata            <= RDATA_IDLE;
		end else if (i_clock_en) begin
			phase_four_steps   <= next_phase_four_steps;
			period_steps       <= next_period_steps;
			dimming_duty_value <= next_dimming_duty_value;
			on_interval_steps  <= next_on_interval_steps;
			o_rdata            <= next_rdata;
		end
	end

	// sequence: on interval, then phase four, restart at period end.
	// a zero period or a disabled sequence leaves plain dimming pwm,
	// so the channel never goes dark just from an unset period
	// step timing
	always_comb begin
		seq_on    = i_seq_enable && (period_steps != STEP_NONE);
		step_plus = {1'b0, step} + {1'b0, STEP_ONE};
		on_ext    = {3'h0, on_interval_steps};
		p4_end    = on_ext + {1'b0, phase_four_steps};
		next_step = step;
		if (!seq_on) begin
			next_step = STEP_NONE;
		end else if (step >= period_steps) begin
			// period shortened under the counter
			next_step = STEP_NONE;
		end else if (tick.step_tick) begin
			if (step_plus >= {1'b0, period_steps}) begin
				next_step = STEP_NONE;
			end else begin
				next_step = step_plus[STEP_W-1:0];
			end
		end
		gate = !seq_on || ({1'b0, step} < on_ext);
		next_phase_four = seq_on && ({1'b0, step} >= on_ext) &&
			({1'b0, step} < p4_end);
	end

	// slot <= duty gives duty+1 slots of 32 high
	// duty fraction
	always_comb begin
		pwm_high   = (tick.slot <= dimming_duty_value);
		next_drive = gate && pwm_high;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			step                <= STEP_RESET;
			o_channel_drive_out <= 1'b0;
			o_phase_four_active <= 1'b0;
		end else if (i_clock_en) begin
			step                <= next_step;
			o_channel_drive_out <= next_drive;
			o_phase_four_active <= next_phase_four;
		end
	end

	assign o_phase_four_steps   = phase_four_steps;
	assign o_period_steps       = period_steps;
	assign o_on_interval_steps  = on_interval_steps;
	assign o_dimming_duty_value = dimming_duty_value;

	AST_PHASE_FOUR_STORE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_wr && i_addr == ADDR_PHASE_FOUR) |=>
		(phase_four_steps == $past(i_wdata[STEP_W-1:0])))
		else $error("phase four length not stored");

	AST_PERIOD_WRAP: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && seq_on && tick.step_tick && !i_wr &&
		step_plus == {1'b0, period_steps}) |=> (step == STEP_NONE))
		else $error("step counter missed the period end");

	AST_PWM_FRACTION: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && gate) |=>
		(o_channel_drive_out == ($past(tick.slot) <=
		$past(dimming_duty_value))))
		else $error("pwm output does not match duty");

	AST_DUTY_ZERO_LOW: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && dimming_duty_value == DUTY_RESET &&
		tick.slot != SLOT_FIRST) |=> !o_channel_drive_out)
		else $error("zero duty output high past first slot");

	AST_DUTY_FULL_HIGH: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && dimming_duty_value == DUTY_FULL && gate) |=>
		o_channel_drive_out)
		else $error("full duty output went low");

	AST_RESERVED_READ_ZERO: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_rd && i_addr == ADDR_DUTY) |=>
		(o_rdata[DATA_W-1:DUTY_W] == 3'h0 &&
		o_rdata[DUTY_W-1:0] == $past(dimming_duty_value)))
		else $error("duty read back wrong");

	AST_RESET_CLEARS: assert property (@(posedge i_clock)
		!i_resetn |=> (phase_four_steps == STEP_RESET &&
		period_steps == STEP_RESET && on_interval_steps == ON_RESET &&
		dimming_duty_value == DUTY_RESET))
		else $error("registers not clear in reset");

	AST_ON_INTERVAL_GATE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && seq_on && {1'b0, step} >= on_ext) |=>
		!o_channel_drive_out)
		else $error("output driven after on interval");

	// register stores and read-back paths
	AST_PERIOD_STORE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_wr && i_addr == ADDR_PERIOD) |=>
		(period_steps == $past(i_wdata[STEP_W-1:0])))
		else $error("period length not stored");

	AST_DUTY_STORE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_wr && i_addr == ADDR_DUTY) |=>
		(dimming_duty_value == $past(i_wdata[DUTY_W-1:0])))
		else $error("duty value not stored");

	AST_ON_TIME_STORE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_wr && i_addr == ADDR_ON_TIME) |=>
		(on_interval_steps == $past(i_wdata[ON_W-1:0])))
		else $error("on interval length not stored");

	AST_PHASE_FOUR_READ: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_rd && i_addr == ADDR_PHASE_FOUR) |=>
		(o_rdata == {1'b0, $past(phase_four_steps)}))
		else $error("phase four length read back wrong");

	AST_PERIOD_READ: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_rd && i_addr == ADDR_PERIOD) |=>
		(o_rdata == {1'b0, $past(period_steps)}))
		else $error("period length read back wrong");

	AST_ON_TIME_READ: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_rd && i_addr == ADDR_ON_TIME) |=>
		(o_rdata == {3'h0, $past(on_interval_steps)}))
		else $error("on interval length read back wrong");

	AST_STEP_READ: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_rd && i_addr == ADDR_STEP) |=>
		(o_rdata == {1'b0, $past(step)}))
		else $error("step counter read back wrong");

	// idle cycles and unmapped addresses read as zero
	AST_RDATA_IDLE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && !i_rd) |=> (o_rdata == RDATA_IDLE))
		else $error("read data left standing");

	AST_UNMAPPED_READ_ZERO: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && i_rd && i_addr != ADDR_PHASE_FOUR &&
		i_addr != ADDR_PERIOD && i_addr != ADDR_DUTY &&
		i_addr != ADDR_ON_TIME && i_addr != ADDR_STEP &&
		i_addr != ADDR_STATUS) |=> (o_rdata == RDATA_IDLE))
		else $error("unmapped read not zero");

	// step counter, phase four flag and drive output
	AST_STEP_IN_PERIOD: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && seq_on && !i_wr &&
		step < period_steps) |=> (step < period_steps))
		else $error("step counter ran past the period");

	AST_STEP_HOLD: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && seq_on && !tick.step_tick &&
		step < period_steps) |=> $stable(step))
		else $error("step counter moved between step ticks");

	AST_SEQ_OFF_PLAIN: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && !seq_on) |=>
		(step == STEP_NONE && !o_phase_four_active))
		else $error("sequence state left with sequence off");

	AST_PHASE_FOUR_FLAG: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && seq_on && {1'b0, step} >= on_ext &&
		{1'b0, step} < p4_end) |=> o_phase_four_active)
		else $error("phase four flag missing in its window");

	AST_ON_INTERVAL_DRIVE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && seq_on && {1'b0, step} < on_ext &&
		dimming_duty_value == DUTY_FULL) |=> o_channel_drive_out)
		else $error("full duty output low in on interval");

	AST_DUTY_ZERO_FIRST_SLOT: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		(i_clock_en && gate && dimming_duty_value == DUTY_RESET &&
		tick.slot == SLOT_FIRST) |=> o_channel_drive_out)
		else $error("zero duty output low in first slot");
endmodule : lcb_blink_timing

// ===== lcb_blink_timing_bench.sv
// self-checking bench for the blink timing block
`timescale 1ns/1ps
module lcb_blink_timing_bench;
	import lcb_pkg::*;
	// short slot keeps one 64 ms step at 1024 clocks
	localparam int SC   = 4;
	localparam int PER  = 32 * SC;
	localparam int STEP = 8 * PER;
	typedef struct {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} lcb_bench_row_t;

	logic              i_clock;
	logic              i_resetn;
	logic              i_clock_en;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata;
	logic              i_wr;
	logic              i_rd;
	logic [DATA_W-1:0] o_rdata;
	logic              i_seq_enable;
	logic              o_channel_drive_out;
	logic              o_phase_four_active;
	logic [STEP_W-1:0] o_phase_four_steps;
	logic [STEP_W-1:0] o_period_steps;
	logic [ON_W-1:0]   o_on_interval_steps;
	logic [DUTY_W-1:0] o_dimming_duty_value;
	int                fails;
	int                n_checks;
	int                hd;
	int                hp;
	logic [7:0]        d;
	lcb_bench_row_t    rows [6];
	logic [7:0]        rd_addr [3] = '{8'h5b, 8'h5c, 8'h5d};
	logic [4:0]        duty    [3] = '{5'h00, 5'h07, 5'h1f};

	lcb_blink_timing #(.SLOT_CYCLES(SC)) uut (
		.i_clock             (i_clock),
		.i_resetn            (i_resetn),
		.i_clock_en          (i_clock_en),
		.i_addr              (i_addr),
		.i_wdata             (i_wdata),
		.i_wr                (i_wr),
		.i_rd                (i_rd),
		.o_rdata             (o_rdata),
		.i_seq_enable        (i_seq_enable),
		.o_channel_drive_out (o_channel_drive_out),
		.o_phase_four_active (o_phase_four_active),
		.o_phase_four_steps  (o_phase_four_steps),
		.o_period_steps      (o_period_steps),
		.o_on_interval_steps (o_on_interval_steps),
		.o_dimming_duty_value(o_dimming_duty_value)
	);

	always #2 i_clock = ~i_clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clock);
		i_addr  <= a;
		i_wdata <= v;
		i_wr    <= 1'b1;
		@(posedge i_clock);
		i_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clock);
		i_rd   <= 1'b0;
		#1 v = o_rdata;
	endtask : rd

	// counts high cycles of drive and phase-four flag
	task automatic meas(input int n, output int cd, output int cp);
		cd = 0;
		cp = 0;
		repeat (n) begin
			@(posedge i_clock);
			#1;
			cd += o_channel_drive_out;
			cp += o_phase_four_active;
		end
	endtask : meas

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		#(60000 * 4);
		fails++;
		wrap_up();
	end

	initial begin
		i_clock = 1'b0; i_resetn = 1'b0; i_clock_en = 1'b1;
		i_addr = 8'h00; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0;
		i_seq_enable = 1'b0; fails = 0; n_checks = 0;
		rows = '{'{8'h5b, 8'hff, 8'h7f}, '{8'h5c, 8'h80, 8'h00},
			'{8'h5d, 8'hff, 8'h1f}, '{8'h5e, 8'hff, 8'h1f},
			'{8'h7e, 8'h55, 8'h00}, '{8'h40, 8'hff, 8'h00}};
		repeat (4) @(posedge i_clock);
		i_resetn <= 1'b1;
		foreach (rd_addr[i]) begin
			rd(rd_addr[i], d);
			check(d, 8'h00);
		end
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, d);
			check(d, rows[i].exp);
		end
		check(o_period_steps, 7'h00);
		check(o_phase_four_steps, 7'h7f);
		check(o_on_interval_steps, 5'h1f);
		// duty sweep with sequence off: high (d+1) slots per period
		foreach (duty[i]) begin
			wr(8'h5d, {3'h0, duty[i]});
			repeat (PER) @(posedge i_clock);
			meas(PER, hd, hp);
			check(hd, (duty[i] + 1) * SC);
		end
		// writes while the clock enable is low are dropped
		@(posedge i_clock);
		i_clock_en <= 1'b0;
		wr(8'h5d, 8'h03);
		i_clock_en <= 1'b1;
		rd(8'h5d, d);
		check(d, 8'h1f);
		// sequence: on 1 step, phase four 1 step, period 3 steps
		wr(8'h5e, 8'h01);
		wr(8'h5b, 8'h01);
		wr(8'h5c, 8'h03);
		i_seq_enable <= 1'b1;
		repeat (3 * STEP) @(posedge i_clock);
		meas(6 * STEP, hd, hp);
		check(hd, 2 * STEP);
		check(hp, 2 * STEP);
		wr(8'h5d, 8'h00);
		repeat (3 * STEP) @(posedge i_clock);
		meas(6 * STEP, hd, hp);
		check(hd, 2 * 8 * SC);
		// second reset in mid-run clears everything
		@(posedge i_clock);
		i_resetn <= 1'b0;
		#1 check(o_phase_four_steps, 7'h00);
		check(o_dimming_duty_value, 5'h00);
		check(o_channel_drive_out, 1'b0);
		@(posedge i_clock);
		i_resetn <= 1'b1;
		rd(8'h5c, d);
		check(d, 8'h00);
		rd(8'h5e, d);
		check(d, 8'h00);
		wrap_up();
	end
endmodule : lcb_blink_timing_bench

// ===== lcb_pkg.sv
// constants and field layout of the blink timing block
// What this block does
// - phase four lasts value times 64 ms
// - sequence period lasts value times 64 ms
// - pwm 8 ms, high (duty+1)/32
// - duty zero: high 250 us only
// - duty all ones: high throughout the on interval or with the sequence off
// - unused bits read zero, read-only
// - all registers clear on power-on reset
// - on interval lasts value times 64 ms
package lcb_pkg;
	// bus layout
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam logic [7:0]  ADDR_PHASE_FOUR = 8'h5b;
	localparam logic [7:0]  ADDR_PERIOD     = 8'h5c;
	localparam logic [7:0]  ADDR_DUTY       = 8'h5d;
	localparam logic [7:0]  ADDR_ON_TIME    = 8'h5e;
	localparam logic [7:0]  ADDR_STEP       = 8'h7e;
	localparam logic [7:0]  ADDR_STATUS     = 8'h7f;
	localparam logic [7:0]  RDATA_IDLE      = 8'h00;

	// field widths and reset values
	localparam int          STEP_W          = 7;
	localparam int          DUTY_W          = 5;
	localparam int          ON_W            = 5;
	localparam logic [6:0]  STEP_RESET      = 7'h00;
	localparam logic [4:0]  DUTY_RESET      = 5'h00;
	localparam logic [4:0]  ON_RESET        = 5'h00;
	localparam logic [4:0]  DUTY_FULL       = 5'h1f;
	localparam logic [6:0]  STEP_NONE       = 7'h00;
	localparam logic [6:0]  STEP_ONE        = 7'h01;

	// timebase: one pwm slot is 1/32 of the 8 ms period
	localparam int          CLOCK_PERIOD_PS = 4000;
	localparam int          SLOT_TIME_US    = 250;
	localparam int          SLOT_CYCLES_DEF =
		(SLOT_TIME_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int          CYC_W           = 16;
	localparam int          SLOT_W          = 5;
	localparam logic [4:0]  SLOT_FIRST      = 5'h00;
	localparam logic [4:0]  SLOT_LAST       = 5'h1f;
	localparam logic [4:0]  SLOT_ONE        = 5'h01;
	// eight pwm periods make one 64 ms step
	localparam int          PRD_W           = 3;
	localparam logic [2:0]  PRD_FIRST       = 3'h0;
	localparam logic [2:0]  PRD_LAST        = 3'h7;
	localparam logic [2:0]  PRD_ONE         = 3'h1;
endpackage : lcb_pkg

// ===== lcb_tick_if.sv
// timebase signals passed from the divider to the sequencer
`timescale 1ns/1ps
interface lcb_tick_if;
	import lcb_pkg::*;
	logic [SLOT_W-1:0] slot;
	logic              slot_tick;
	logic              step_tick;
	modport src (output slot, output slot_tick, output step_tick);
	modport snk (input slot, input slot_tick, input step_tick);
endinterface : lcb_tick_if

// ===== lcb_timebase.sv
// common slot, pwm period and step timebase
`timescale 1ns/1ps
module lcb_timebase
	import lcb_pkg::*;
#(
	parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEF
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_resetn,
	input  wire logic i_clock_en,
	// ticks out
	lcb_tick_if.src   tick
);
	localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(SLOT_CYCLES - 1);
	localparam logic [CYC_W-1:0] CYC_ZERO = '0;
	localparam logic [CYC_W-1:0] CYC_ONE  = CYC_W'(1);

	logic [CYC_W-1:0]  cyc;
	logic [SLOT_W-1:0] slot;
	logic [PRD_W-1:0]  prd;
	logic [CYC_W-1:0]  next_cyc;
	logic [SLOT_W-1:0] next_slot;
	logic [PRD_W-1:0]  next_prd;
	logic              slot_end;

	// step derived from the same slot counter
	// shared timebase
	always_comb begin
		slot_end  = (cyc == CYC_LAST);
		next_cyc  = slot_end ? CYC_ZERO : cyc + CYC_ONE;
		next_slot = slot;
		next_prd  = prd;
		if (slot_end) begin
			next_slot = slot + SLOT_ONE;
			if (slot == SLOT_LAST) begin
				next_prd = prd + PRD_ONE;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			cyc  <= CYC_ZERO;
			slot <= SLOT_FIRST;
			prd  <= PRD_FIRST;
		end else if (i_clock_en) begin
			cyc  <= next_cyc;
			slot <= next_slot;
			prd  <= next_prd;
		end
	end

	assign tick.slot      = slot;
	assign tick.slot_tick = slot_end && i_clock_en;
	assign tick.step_tick = slot_end && i_clock_en &&
		(slot == SLOT_LAST) && (prd == PRD_LAST);

	AST_STEP_ON_PERIOD_EDGE: assert property (@(posedge i_clock)
		disable iff (!i_resetn)
		tick.step_tick |=> (slot == SLOT_FIRST && prd == PRD_FIRST))
		else $error("step tick did not restart the pwm periods");
endmodule : lcb_timebase
